// file: odgc_pkg.sv
// shared constants for the output driver gating control block
package odgc_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;   // clk_i period
   localparam int unsigned INIT_TIME_NS  = 160;  // divider hold after any reset
   localparam int unsigned INIT_CYC      = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 5;    // init and synth counter width
   localparam int unsigned SYN_BASE_HALF = 1;    // half period of synth 0, cycles

   // register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;    // hard reset, zero delay, hitless
   localparam logic [7:0] ADR_DIS    = 8'h04;    // per-driver disable
   localparam logic [7:0] ADR_PARK   = 8'h08;    // parked level high
   localparam logic [7:0] ADR_SYNC   = 8'h0c;    // synchronous disable select
   localparam logic [7:0] ADR_SE     = 8'h10;    // single-ended mode
   localparam logic [7:0] ADR_POLT   = 8'h14;    // invert true pin
   localparam logic [7:0] ADR_POLC   = 8'h18;    // invert complement pin
   localparam logic [7:0] ADR_DRV    = 8'h1c;    // drive strength, 2 bits each
   localparam logic [7:0] ADR_VDDO18 = 8'h20;    // driver supply is 1.8 V
   localparam logic [7:0] ADR_XPT    = 8'h24;    // crosspoint, 3 bits each
   localparam logic [7:0] ADR_STAT   = 8'h28;    // running drivers, divider reset

   // field positions
   localparam int unsigned CTRL_HRST_BIT    = 0;
   localparam int unsigned CTRL_ZDM_BIT     = 1;
   localparam int unsigned CTRL_HITLESS_BIT = 2;
   localparam int unsigned STAT_DIVRST_BIT  = 31;
   localparam int unsigned XPT_W            = 3;

   // drive strength codes
   localparam logic [1:0] DRV_CODE1 = 2'h1;      // weakest, not at 1.8 V
   localparam logic [1:0] DRV_CODE2 = 2'h2;
   localparam logic [1:0] DRV_CODE3 = 2'h3;      // strongest

   // values after reset
   localparam logic [1:0] DRV_RST     = DRV_CODE3;
   localparam logic       HITLESS_RST = 1'b1;
endpackage

// file: odgc_top.sv
// output driver gating, polarity, drive and divider reset with wishbone registers
//
// How it works
// - off pin high disables every driver
// - off pin low lets drivers run
// - per-driver register disable bit
// - per-driver parked level low or high
// - synchronous disable waits for period end
// - immediate disable stops clock at once
// - any driver may be single-ended
// - single-ended drives clock on both pins
// - after reset single-ended pins in phase
// - per-pin polarity invert for single-ended
// - drive codes 1..3, no 1 at 1.8 V
// - power-up holds output dividers in reset
// - reset pin or hard bit resets dividers
// - zero delay opens internal feedback path
// - zero delay forbids hitless switching
// - crosspoint picks any synthesizer per driver
`timescale 1ns/10ps
module odgc_top #(
   parameter int unsigned NUM_DRV = 10,   // output drivers, at most 10
   parameter int unsigned NUM_SYN = 5     // synthesizers, at most 8
) (
   // clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           rst_i,
   // wishbone slave
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   input  wire logic                           wb_we_i,
   input  wire logic [7:0]                     wb_adr_i,
   input  wire logic [3:0]                     wb_sel_i,
   input  wire logic [31:0]                    wb_dat_i,
   output logic      [31:0]                    wb_dat_o,
   output logic                                wb_ack_o,
   // device pins
   input  wire logic                           drivers_off_pin_i,
   input  wire logic                           device_reset_pin_n_i,
   output logic      [NUM_DRV-1:0]             clk_out_true_o,
   output logic      [NUM_DRV-1:0]             clk_out_comp_o,
   // driver analog controls
   output logic      [NUM_DRV-1:0]             single_ended_o,
   output logic      [2*NUM_DRV-1:0]           single_ended_drive_select_o,
   // loop controls
   output logic                                feedback_open_o,
   output logic                                hitless_enable_o
);
   import odgc_pkg::*;

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   // legal drive code for the given supply
   function automatic logic drv_ok(input logic [1:0] code, input logic v18);
      return (code != 2'h0) && !(v18 && (code == DRV_CODE1));
   endfunction

   // pin synchronisers
   logic                 off_s1;       // first stage, read by off_s2 only
   logic                 off_s2;       // off pin in clk_i domain
   logic                 rst_s1;       // first stage, read by rst_s2 only
   logic                 rst_s2;       // reset pin, low = reset
   // software registers
   logic                 hard_rst;     // one-cycle pulse
   logic                 zero_delay;
   logic                 hitless_req;
   logic [NUM_DRV-1:0]   dis;
   logic [NUM_DRV-1:0]   park_high;
   logic [NUM_DRV-1:0]   sync_dis;
   logic [NUM_DRV-1:0]   se_mode;
   logic [NUM_DRV-1:0]   pol_t;
   logic [NUM_DRV-1:0]   pol_c;
   logic [2*NUM_DRV-1:0] drv;
   logic [NUM_DRV-1:0]   vddo18;
   logic [XPT_W*NUM_DRV-1:0] xpt;
   // clock path state
   logic [CNT_W-1:0]     init_cnt;     // counts down divider hold
   logic [CNT_W-1:0]     syn_cnt [NUM_SYN];
   logic [NUM_SYN-1:0]   syn_clk;      // synthesizer outputs
   logic [NUM_DRV-1:0]   rdiv;         // output divider state
   logic [NUM_DRV-1:0]   stopped;      // driver parked

   // bus decode
   wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;   // lands at the ack edge
   wire [31:0] z   = 32'h0;
   wire        div_rst = (init_cnt != '0) | hard_rst | ~rst_s2;

   // registers widened to bus words
   wire [31:0] w_dis  = {z[31:NUM_DRV], dis};
   wire [31:0] w_park = {z[31:NUM_DRV], park_high};
   wire [31:0] w_sync = {z[31:NUM_DRV], sync_dis};
   wire [31:0] w_se   = {z[31:NUM_DRV], se_mode};
   wire [31:0] w_polt = {z[31:NUM_DRV], pol_t};
   wire [31:0] w_polc = {z[31:NUM_DRV], pol_c};
   wire [31:0] w_v18  = {z[31:NUM_DRV], vddo18};
   wire [31:0] w_drv  = {z[31:2*NUM_DRV], drv};
   wire [31:0] w_xpt  = {z[31:XPT_W*NUM_DRV], xpt};
   wire [31:0] w_ctrl = {29'h0, hitless_req, zero_delay, 1'b0};
   wire [31:0] w_stat = {div_rst, z[30:NUM_DRV], ~stopped};

   // read selection, unmapped reads zero
   wire [31:0] rd_word =
      (wb_adr_i == ADR_CTRL)   ? w_ctrl :
      (wb_adr_i == ADR_DIS)    ? w_dis  :
      (wb_adr_i == ADR_PARK)   ? w_park :
      (wb_adr_i == ADR_SYNC)   ? w_sync :
      (wb_adr_i == ADR_SE)     ? w_se   :
      (wb_adr_i == ADR_POLT)   ? w_polt :
      (wb_adr_i == ADR_POLC)   ? w_polc :
      (wb_adr_i == ADR_DRV)    ? w_drv  :
      (wb_adr_i == ADR_VDDO18) ? w_v18  :
      (wb_adr_i == ADR_XPT)    ? w_xpt  :
      (wb_adr_i == ADR_STAT)   ? w_stat : z;

   // merged write data per register
   wire [31:0] m_ctrl = merge(w_ctrl, wb_dat_i, wb_sel_i);
   wire [31:0] m_drv  = merge(w_drv, wb_dat_i, wb_sel_i);
   wire [31:0] m_v18  = merge(w_v18, wb_dat_i, wb_sel_i);

   // single cycle ack, read data captured with it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= acc;
         wb_dat_o <= (acc & ~wb_we_i) ? rd_word : 32'h0;
      end
   end

   // two flops on each pin before any logic looks at it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         off_s1 <= 1'b1;
         off_s2 <= 1'b1;
         rst_s1 <= 1'b1;
         rst_s2 <= 1'b1;
      end
      else
      begin
         off_s1 <= drivers_off_pin_i;
         off_s2 <= off_s1;
         rst_s1 <= device_reset_pin_n_i;
         rst_s2 <= rst_s1;
      end
   end

   // control and mode registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hard_rst    <= 1'b0;
         zero_delay  <= 1'b0;
         hitless_req <= HITLESS_RST;
      end
      else if (wr && wb_adr_i == ADR_CTRL)
      begin
         hard_rst    <= m_ctrl[CTRL_HRST_BIT];
         zero_delay  <= m_ctrl[CTRL_ZDM_BIT];
         hitless_req <= m_ctrl[CTRL_HITLESS_BIT];
      end
      else
         hard_rst    <= 1'b0;                    // self-clearing
   end

   // per-driver bit registers; zero polarity bits keep single-ended pins in phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dis       <= '0;
         park_high <= '0;
         sync_dis  <= '0;
         se_mode   <= '0;
         pol_t     <= '0;
         pol_c     <= '0;
         vddo18    <= '0;
         xpt       <= '0;
      end
      else if (wr)
      begin
         if (wb_adr_i == ADR_DIS)    dis       <= NUM_DRV'(merge(w_dis, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_PARK)   park_high <= NUM_DRV'(merge(w_park, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_SYNC)   sync_dis  <= NUM_DRV'(merge(w_sync, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_SE)     se_mode   <= NUM_DRV'(merge(w_se, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_POLT)   pol_t     <= NUM_DRV'(merge(w_polt, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_POLC)   pol_c     <= NUM_DRV'(merge(w_polc, wb_dat_i, wb_sel_i));
         if (wb_adr_i == ADR_VDDO18) vddo18    <= NUM_DRV'(m_v18);
         if (wb_adr_i == ADR_XPT)    xpt       <= (XPT_W*NUM_DRV)'(merge(w_xpt, wb_dat_i, wb_sel_i));
      end
   end

   // drive fields: an illegal code in a write leaves that field unchanged
   logic [2*NUM_DRV-1:0] next_drv;
   logic [2*NUM_DRV-1:0] next_dsel;
   logic [NUM_DRV-1:0]   next_true;
   logic [NUM_DRV-1:0]   next_comp;
   logic [NUM_DRV-1:0]   next_rdiv;
   logic [NUM_DRV-1:0]   next_stopped;
   logic [CNT_W-1:0]     next_syn_cnt [NUM_SYN];
   logic [NUM_SYN-1:0]   syn_tick;       // synth about to rise
   logic [NUM_SYN-1:0]   syn_wrap;       // synth counter at its last count

   // synthesizers: free dividers of clk_i, each a little slower
   for (genvar s = 0; s < NUM_SYN; s++)
   begin : g_syn
      localparam logic [CNT_W-1:0] HALF = CNT_W'(SYN_BASE_HALF + s);
      assign syn_wrap[s]     = (syn_cnt[s] == HALF - 1'b1);
      assign syn_tick[s]     = syn_wrap[s] & ~syn_clk[s];
      assign next_syn_cnt[s] = syn_wrap[s] ? '0 : syn_cnt[s] + 1'b1;
   end

   for (genvar i = 0; i < NUM_DRV; i++)
   begin : g_drv
      wire [1:0]       wcode = m_drv[2*i +: 2];
      wire [1:0]       code  = drv[2*i +: 2];
      wire [XPT_W-1:0] xsel  = xpt[XPT_W*i +: XPT_W];
      // out-of-range crosspoint codes fall back to synth 0
      wire [XPT_W-1:0] ssel  = (32'(xsel) < NUM_SYN) ? xsel : '0;
      wire tick   = syn_tick[ssel];
      wire fall   = rdiv[i] & tick;                                   // period ends
      wire req    = off_s2 | dis[i];
      wire park   = park_high[i];
      assign next_drv[2*i +: 2] =
         (wr && wb_adr_i == ADR_DRV && drv_ok(wcode, vddo18[i])) ? wcode : code;
      // a weak code left over from another supply is lifted one step
      assign next_dsel[2*i +: 2] = (vddo18[i] && code == DRV_CODE1) ? DRV_CODE2 : code;
      assign next_rdiv[i] = div_rst ? 1'b0 : (rdiv[i] ^ tick);
      // sync mode stops only at a falling edge and restarts from low
      assign next_stopped[i] = req ? (stopped[i] | ~sync_dis[i] | fall)
                                   : (stopped[i] & sync_dis[i] & rdiv[i]);
      assign next_true[i] = stopped[i] ? park : (rdiv[i] ^ pol_t[i]);
      // single-ended drives a clock on the complement pin too
      assign next_comp[i] = stopped[i] ? (se_mode[i] ? park : ~park)
                          : (se_mode[i] ? (rdiv[i] ^ pol_c[i]) : ~rdiv[i]);
   end

   // clock path flops; drivers stay parked until the reset is over
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         init_cnt <= CNT_W'(INIT_CYC);
         syn_clk  <= '0;
         for (int s = 0; s < NUM_SYN; s++)
            syn_cnt[s] <= '0;
         rdiv     <= '0;
         stopped  <= '1;
         drv      <= {NUM_DRV{DRV_RST}};
      end
      else
      begin
         // pin or hard bit restarts the whole hold period
         init_cnt <= (hard_rst | ~rst_s2) ? CNT_W'(INIT_CYC)
                   : (init_cnt != '0) ? init_cnt - 1'b1 : init_cnt;
         for (int s = 0; s < NUM_SYN; s++)
            syn_cnt[s] <= div_rst ? '0 : next_syn_cnt[s];
         syn_clk  <= div_rst ? '0 : (syn_clk ^ syn_wrap);   // toggles at each wrap
         rdiv     <= next_rdiv;
         stopped  <= next_stopped;
         drv      <= next_drv;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clk_out_true_o              <= '0;
         clk_out_comp_o              <= '1;
         single_ended_o              <= '0;
         single_ended_drive_select_o <= {NUM_DRV{DRV_RST}};
         feedback_open_o             <= 1'b0;
         hitless_enable_o            <= 1'b0;
      end
      else
      begin
         clk_out_true_o              <= next_true;
         clk_out_comp_o              <= next_comp;
         single_ended_o              <= se_mode;
         single_ended_drive_select_o <= next_dsel;
         feedback_open_o             <= zero_delay;
         hitless_enable_o            <= hitless_req & ~zero_delay;
      end
   end

   // checks on driver 0 and the shared paths
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_pin_off_stop: assert property (off_s2 && !sync_dis[0] |=> stopped[0])
      else $error("off pin did not stop driver");
   chk_pin_on_run: assert property (!off_s2 && !dis[0] && !sync_dis[0] |=> !stopped[0])
      else $error("driver not running with pin low");
   chk_reg_dis_stop: assert property (dis[0] && !sync_dis[0]
                                      |=> ##1 clk_out_true_o[0] == $past(park_high[0]))
      else $error("register disable ignored");
   chk_park_level: assert property (stopped[0]
                                    |=> clk_out_true_o[0] == $past(park_high[0]))
      else $error("wrong parked level");
   chk_sync_no_runt: assert property ($rose(stopped[0]) && $past(sync_dis[0])
                                      |-> !rdiv[0] && $past(rdiv[0]))
      else $error("sync disable cut a period");
   chk_se_in_phase: assert property (se_mode[0] && !stopped[0] && !pol_t[0] && !pol_c[0]
                                     |=> clk_out_true_o[0] == clk_out_comp_o[0])
      else $error("single-ended pins out of phase");
   chk_drive_legal: assert property (##1 single_ended_drive_select_o[1:0] != 2'h0 &&
      !($past(vddo18[0]) && single_ended_drive_select_o[1:0] == DRV_CODE1))
      else $error("illegal drive code");
   chk_div_reset: assert property (div_rst |=> rdiv == '0 && syn_clk == '0)
      else $error("dividers not held in reset");
   chk_hard_reset: assert property (hard_rst |=> div_rst [*8])
      else $error("hard reset did not hold dividers");
   chk_zdm_hitless: assert property (zero_delay |=> feedback_open_o && !hitless_enable_o)
      else $error("hitless allowed in zero delay");
   chk_xpt_follow: assert property (!div_rst && syn_tick[xpt[XPT_W-1:0]] &&
                                    32'(xpt[XPT_W-1:0]) < NUM_SYN |=> $changed(rdiv[0]))
      else $error("driver not following its synth");
   chk_off_sync: assert property (!$past(rst_i) && !$past(rst_i, 2)
                                  |-> off_s2 == $past(drivers_off_pin_i, 2))
      else $error("off pin not synchronised");
endmodule

// file: odgc_rx_model.sv
// downstream clock receiver model that measures high pulses on driver 0
`timescale 1ns/10ps
module odgc_rx_model (
   // sampling clock and restart of the measurement
   input  wire logic       clk_i,
   input  wire logic       clear_i,
   // true pin of the watched driver
   input  wire logic       pin_true_i,
   // shortest complete high pulse seen, in clock cycles
   output logic      [7:0] min_high_o
);
   logic [7:0] run;   // length of the high pulse in progress

   // a receiver only counts a pulse when it ends, so a runt shows as short
   always_ff @(posedge clk_i)
   begin
      if (pin_true_i)
         run <= run + 8'h01;
      else
         run <= 8'h00;
      if (clear_i)
         min_high_o <= 8'hff;
      else if (!pin_true_i && run != 8'h00 && run < min_high_o)
         min_high_o <= run;
   end
endmodule

// file: odgc_top_tb.sv
// self-checking bench for the output driver gating control block
`timescale 1ns/10ps
module odgc_top_tb;
   import odgc_pkg::*;
   logic        clk_i = 1'b0;       // 100 MHz bench clock
   logic        rst_i = 1'b1;       // sync reset, held 2 cycles
   logic        cyc = 1'b0;         // wishbone request lines
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'hf;         // full words only
   logic        off = 1'b0;         // global driver-off pin
   logic        rst_pin_n = 1'b1;   // device reset pin
   logic        clr = 1'b1;         // receiver measurement restart
   logic [31:0] rdat;               // read data from the slave
   logic        ack;
   logic [9:0]  ct, cc, se;         // pin pairs and mode copy
   logic [19:0] drv;                // drive code fields
   logic        fb_open, hitless;
   logic [7:0]  min_high;           // receiver report
   logic [31:0] seed = 32'ha10b0982;
   logic [31:0] q;
   int          n_fail = 0;
   int          total_checks = 0;

   odgc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .drivers_off_pin_i(off), .device_reset_pin_n_i(rst_pin_n),
      .clk_out_true_o(ct), .clk_out_comp_o(cc), .single_ended_o(se),
      .single_ended_drive_select_o(drv), .feedback_open_o(fb_open),
      .hitless_enable_o(hitless));
   odgc_rx_model rx (.clk_i(clk_i), .clear_i(clr), .pin_true_i(ct[0]), .min_high_o(min_high));

   always #5 clk_i = ~clk_i;

   // next value of the bench's random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one classic cycle; the master holds everything until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1)
      begin
         n_fail++;
         end_of_test();
      end
   endtask

   // settle n edges and look just after the last one
   task automatic pause(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // changes of true pin 0 over eight clock intervals
   task automatic toggles(output logic [31:0] t);
      logic p;
      t = 0;
      pause(1);
      p = ct[0];
      repeat (8)
      begin
         pause(1);
         t += (ct[0] !== p);
         p = ct[0];
      end
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      pause(2);
      check({30'h0, fb_open, hitless}, 32'h1);
      check(drv, 32'hfffff);
      wb(1'b0, ADR_STAT, 0);
      check(q[31], 1);
      pause(30);
      wb(1'b0, ADR_STAT, 0);
      check(q, 32'h3ff);
      wb(1'b0, 8'h80, 0);
      check(q, 0);
      $display("test reset and start done");
      // parked levels, a corner then random patterns
      for (int k = 0; k < 5; k++)
      begin
         seed = lfsr(seed);
         wb(1'b1, ADR_PARK, k == 0 ? 32'h3ff : {22'h0, seed[9:0]});
         wb(1'b1, ADR_DIS, 32'h3ff);
         pause(8);
         check(ct, k == 0 ? 32'h3ff : seed[9:0]);
         check(cc, k == 0 ? 32'h0 : {22'h0, ~seed[9:0]});
         wb(1'b1, ADR_DIS, 0);
      end
      wb(1'b1, ADR_PARK, 0);
      pause(10);
      @(posedge clk_i) off <= 1'b1;
      pause(10);
      check({ct, cc}, 20'h003ff);
      wb(1'b0, ADR_STAT, 0);
      check(q, 0);
      @(posedge clk_i) off <= 1'b0;
      pause(30);
      wb(1'b0, ADR_STAT, 0);
      check(q, 32'h3ff);
      $display("test disable and park done");
      // single-ended pairs: in phase, then complementary, then other synth
      wb(1'b1, ADR_SE, 32'h3ff);
      pause(6);
      check(se, 32'h3ff);
      toggles(q);
      check(q, 4);
      check(cc, ct);
      wb(1'b1, ADR_POLC, 32'h3ff);
      pause(4);
      check(cc ^ ct, 32'h3ff);
      wb(1'b1, ADR_POLC, 0);
      wb(1'b1, ADR_POLT, 32'h3ff);
      pause(4);
      check(cc ^ ct, 32'h3ff);
      wb(1'b1, ADR_POLT, 0);
      wb(1'b1, ADR_XPT, 32'h1);
      pause(12);
      toggles(q);
      check(q, 2);
      wb(1'b1, ADR_XPT, 0);
      wb(1'b1, ADR_SE, 0);
      $display("test single ended done");
      // drive codes: code 0 always refused, code 1 refused at 1.8 V
      wb(1'b1, ADR_DRV, 32'h55555);
      pause(2);
      check(drv, 32'h55555);
      wb(1'b1, ADR_DRV, 0);
      pause(2);
      check(drv, 32'h55555);
      wb(1'b1, ADR_DRV, 32'haaaaa);
      pause(2);
      check(drv, 32'haaaaa);
      wb(1'b1, ADR_VDDO18, 32'h3ff);
      wb(1'b1, ADR_DRV, 32'h55555);
      pause(2);
      check(drv, 32'haaaaa);
      $display("test drive select done");
      // zero delay and divider resets
      wb(1'b1, ADR_CTRL, 32'h6);
      pause(2);
      check({30'h0, fb_open, hitless}, 32'h2);
      wb(1'b1, ADR_CTRL, 32'h5);
      wb(1'b0, ADR_STAT, 0);
      check(q[31], 1);
      wb(1'b0, ADR_CTRL, 0);
      check(q, 32'h4);
      pause(30);
      @(posedge clk_i) rst_pin_n <= 1'b0;
      pause(3);
      @(posedge clk_i) rst_pin_n <= 1'b1;
      wb(1'b0, ADR_STAT, 0);
      check(q[31], 1);
      pause(30);
      $display("test zero delay and resets done");
      // synchronous disable on driver 0, immediate on driver 1, random phase
      wb(1'b1, ADR_SYNC, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         pause(5 + seed[1:0]);
         clr <= 1'b0;
         wb(1'b1, ADR_DIS, 32'h3);
         pause(3);
         check(ct[1], 0);
         pause(6);
         check(min_high, 2);
         clr <= 1'b1;
         wb(1'b1, ADR_DIS, 0);
      end
      $display("test sync disable done");
      end_of_test();
   end
endmodule
